// *** mmpc_pkg.sv ***
// Constants, field layout and timing for the PHY management and pause control block.
// Assumes a single 25 MHz clock shared by both ends of the register port.

`default_nettype none

package mmpc_pkg;

	// ----------------------------------------
	// Register map of the device end
	// ----------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] IDX_ACC = 6'h06;
	localparam logic [ADDR_W-1:0] IDX_DATA = 6'h07;
	localparam logic [ADDR_W-1:0] IDX_FLOW = 6'h08;
	localparam logic [ADDR_W-1:0] ADR_ACC = 6'h18;
	localparam logic [ADDR_W-1:0] ADR_DATA = 6'h1C;
	localparam logic [ADDR_W-1:0] ADR_FLOW = 6'h20;
	localparam logic [31:0] RST_ACC = 32'h00000000;
	localparam logic [31:0] RST_DATA = 32'h00000000;
	localparam logic [31:0] RST_FLOW = 32'h00000000;

	// Access register fields
	localparam int ACC_BUSY = 0;
	localparam int ACC_WNR = 1;
	localparam int ACC_IDX_LO = 6;
	localparam int ACC_PHY_LO = 11;
	localparam logic [4:0] PHY_ADDR_REQ = 5'h01;

	// Flow control register fields
	localparam int FLOW_BUSY = 0;
	localparam int FLOW_EN = 1;
	localparam int FLOW_PASS = 2;
	localparam int FLOW_PT_LO = 16;

	// ----------------------------------------
	// Host end command port
	// ----------------------------------------
	localparam logic [3:0] HOST_CMD = 4'h0;
	localparam logic [3:0] HOST_ARG = 4'h4;
	localparam logic [3:0] HOST_STAT = 4'h8;
	localparam int CMD_WR = 8;
	localparam int CMD_FLOW = 9;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 40;
	localparam int MDC_HALF_NS = 200;
	localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int SLOT_NS = 5120;
	localparam int SLOT_CYC = SLOT_NS / CLK_NS;

	// ----------------------------------------
	// Management frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 64;
	localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
	localparam logic [1:0] SOF = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] TA_WRITE = 2'h2;
	localparam logic [5:0] TA_BIT = 6'h2E;
	localparam logic [5:0] DATA_BIT = 6'h30;
	localparam logic [5:0] LAST_BIT = 6'h3F;

endpackage : mmpc_pkg

`default_nettype wire

// *** mmpc_bus_if.sv ***
// Register port joining host end and device end.
// Assumes both ends run on the same clock; read data follow a read strobe by one cycle.
`timescale 1ns/1ps
`default_nettype none

interface mmpc_bus_if;
	logic [mmpc_pkg::ADDR_W-1:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;

	// Device answers, host drives
	modport dev (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : mmpc_bus_if

`default_nettype wire

// *** mmpc_dev.sv ***
// Device end: management register set, clause 22 frame engine and pause/backpressure control.
// Assumes MDIO is a pin outside the clock domain; flow inputs come from MAC logic on CLK.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module mmpc_dev #(
	parameter int MDC_HALF = mmpc_pkg::MDC_HALF_CYC,
	parameter int SLOT_CYCLES = mmpc_pkg::SLOT_CYC
) (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE,
	// Register port
	mmpc_bus_if.dev BUS,
	// PHY management pins
	output logic MDC,
	input wire logic MDIO_I,
	output logic MDIO_O,
	output logic MDIO_OE,
	// Transmit side flow control
	input wire logic FULL_DUPLEX,
	input wire logic TX_ENABLE,
	input wire logic FC_REQ,
	input wire logic PAUSE_SENT,
	output logic PAUSE_SEND,
	output logic [15:0] PAUSE_TIME,
	output logic BACKPRESSURE,
	output logic TX_HOLD,
	// Receive side flow control
	input wire logic RX_PAUSE_VALID,
	input wire logic [15:0] RX_PAUSE_QUANTA,
	output logic RX_FILTER_FLAG
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [4:0] phy_r;
	logic [4:0] idx_r;
	logic wnr_r;
	logic busy_r;
	logic [15:0] data_r;
	logic [15:0] pt_r;
	logic en_r;
	logic pass_r;
	logic fd_busy_r;
	logic bp_r;
	logic flow_busy;
	logic [31:0] rdata_r;
	logic mdio_m_r;
	logic mdio_s_r;
	logic mdc_r;
	logic mdio_o_r;
	logic mdio_oe_r;
	logic [5:0] bit_r;
	logic [5:0] bit_nxt;
	logic [3:0] half_r;
	logic [63:0] frame_r;
	logic [15:0] cap_r;
	logic half_end;
	logic start;
	logic done;
	logic [15:0] quanta_r;
	logic [7:0] slot_r;
	logic filt_r;
	logic wr_acc;
	logic wr_data;
	logic wr_flow;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Access and data writes during a busy access are dropped so a running frame never changes
	assign wr_acc = BUS.wr && (BUS.addr == mmpc_pkg::ADR_ACC) && !busy_r;
	assign wr_data = BUS.wr && (BUS.addr == mmpc_pkg::ADR_DATA) && !busy_r;
	assign wr_flow = BUS.wr && (BUS.addr == mmpc_pkg::ADR_FLOW) && !flow_busy;
	assign start = wr_acc && BUS.wdata[mmpc_pkg::ACC_BUSY];
	assign half_end = busy_r && (half_r == 4'(MDC_HALF - 1));
	assign done = half_end && mdc_r && (bit_r == mmpc_pkg::LAST_BIT);
	assign bit_nxt = bit_r + 6'h01;

	// ----------------------------------------
	// Access register
	// ----------------------------------------
	// Reserved bits are not stored, so they read back as zero
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			phy_r <= mmpc_pkg::RST_ACC[mmpc_pkg::ACC_PHY_LO +: 5];
			idx_r <= mmpc_pkg::RST_ACC[mmpc_pkg::ACC_IDX_LO +: 5];
			wnr_r <= mmpc_pkg::RST_ACC[mmpc_pkg::ACC_WNR];
		end else if (CE && wr_acc) begin
			phy_r <= BUS.wdata[mmpc_pkg::ACC_PHY_LO +: 5];
			idx_r <= BUS.wdata[mmpc_pkg::ACC_IDX_LO +: 5];
			wnr_r <= BUS.wdata[mmpc_pkg::ACC_WNR];
		end
	end

	// Busy set by software only, cleared by the engine at frame end
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			busy_r <= mmpc_pkg::RST_ACC[mmpc_pkg::ACC_BUSY];
		end else if (CE) begin
			if (start) begin
				busy_r <= 1'b1;
			end else if (done) begin
				busy_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Data register
	// ----------------------------------------
	// Read result lands only as busy falls, never piecewise
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			data_r <= mmpc_pkg::RST_DATA[15:0];
		end else if (CE) begin
			if (wr_data) begin
				data_r <= BUS.wdata[15:0];
			end else if (done && !wnr_r) begin
				data_r <= cap_r;
			end
		end
	end

	// ----------------------------------------
	// Flow control register
	// ----------------------------------------
	// Busy bit is hardware owned; its write value is ignored
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pt_r <= mmpc_pkg::RST_FLOW[mmpc_pkg::FLOW_PT_LO +: 16];
			en_r <= mmpc_pkg::RST_FLOW[mmpc_pkg::FLOW_EN];
			pass_r <= mmpc_pkg::RST_FLOW[mmpc_pkg::FLOW_PASS];
		end else if (CE && wr_flow) begin
			pt_r <= BUS.wdata[mmpc_pkg::FLOW_PT_LO +: 16];
			en_r <= BUS.wdata[mmpc_pkg::FLOW_EN];
			pass_r <= BUS.wdata[mmpc_pkg::FLOW_PASS];
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Unmapped addresses read zero
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_r <= 32'h00000000;
		end else if (CE && BUS.rd) begin
			unique case (BUS.addr)
				mmpc_pkg::ADR_ACC: rdata_r <= {16'h0000, phy_r, idx_r, 4'h0, wnr_r, busy_r};
				mmpc_pkg::ADR_DATA: rdata_r <= {16'h0000, data_r};
				mmpc_pkg::ADR_FLOW: rdata_r <= {pt_r, 13'h0000, pass_r, en_r, flow_busy};
				default: rdata_r <= 32'h00000000;
			endcase
		end
	end
	assign BUS.rdata = rdata_r;

	// ----------------------------------------
	// MDIO input synchroniser
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mdio_m_r <= 1'b1;
			mdio_s_r <= 1'b1;
		end else if (CE) begin
			mdio_m_r <= MDIO_I;
			mdio_s_r <= mdio_m_r;
		end
	end

	// ----------------------------------------
	// Clause 22 frame engine
	// ----------------------------------------
	// Bits change on MDC fall; read data sampled on MDC rise. The two-flop
	// delay is well inside the low half, so the sample stays in its bit.
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mdc_r <= 1'b0;
			mdio_o_r <= 1'b0;
			mdio_oe_r <= 1'b0;
			bit_r <= 6'h00;
			half_r <= 4'h0;
			frame_r <= 64'h0000000000000000;
			cap_r <= 16'h0000;
		end else if (CE) begin
			if (start) begin
				frame_r <= {mmpc_pkg::PREAMBLE, mmpc_pkg::SOF,
					BUS.wdata[mmpc_pkg::ACC_WNR] ? mmpc_pkg::OP_WRITE : mmpc_pkg::OP_READ,
					BUS.wdata[mmpc_pkg::ACC_PHY_LO +: 5], BUS.wdata[mmpc_pkg::ACC_IDX_LO +: 5],
					mmpc_pkg::TA_WRITE, data_r};
				mdio_o_r <= 1'b1;
				mdio_oe_r <= 1'b1;
				mdc_r <= 1'b0;
				bit_r <= 6'h00;
				half_r <= 4'h0;
			end else if (busy_r) begin
				half_r <= half_end ? 4'h0 : half_r + 4'h1;
				if (half_end && !mdc_r) begin
					mdc_r <= 1'b1;
					if (!wnr_r && bit_r >= mmpc_pkg::DATA_BIT) begin
						cap_r <= {cap_r[14:0], mdio_s_r};
					end
				end else if (half_end) begin
					mdc_r <= 1'b0;
					if (done) begin
						mdio_oe_r <= 1'b0;
					end else begin
						bit_r <= bit_nxt;
						frame_r <= {frame_r[62:0], 1'b0};
						mdio_o_r <= frame_r[62];
						mdio_oe_r <= wnr_r || (bit_nxt < mmpc_pkg::TA_BIT);
					end
				end
			end
		end
	end
	assign MDC = mdc_r;
	assign MDIO_O = mdio_o_r;
	assign MDIO_OE = mdio_oe_r;

	// ----------------------------------------
	// Pause frame request and backpressure
	// ----------------------------------------
	// A pause frame once started runs to the end even if TX drops later
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			fd_busy_r <= 1'b0;
			bp_r <= 1'b0;
		end else if (CE) begin
			if (!fd_busy_r && FC_REQ && TX_ENABLE && FULL_DUPLEX) begin
				fd_busy_r <= 1'b1;
			end else if (PAUSE_SENT) begin
				fd_busy_r <= 1'b0;
			end
			bp_r <= FC_REQ && TX_ENABLE && en_r && !FULL_DUPLEX;
		end
	end
	assign flow_busy = fd_busy_r || bp_r;
	assign PAUSE_SEND = fd_busy_r;
	assign PAUSE_TIME = pt_r;
	assign BACKPRESSURE = bp_r;

	// ----------------------------------------
	// Received pause: transmit stall timer
	// ----------------------------------------
	// A new pause frame reloads the timer, zero quanta resumes at once
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			quanta_r <= 16'h0000;
			slot_r <= 8'h00;
		end else if (CE) begin
			if (RX_PAUSE_VALID && en_r && FULL_DUPLEX) begin
				quanta_r <= RX_PAUSE_QUANTA;
				slot_r <= 8'h00;
			end else if (quanta_r != 16'h0000) begin
				if (slot_r == 8'(SLOT_CYCLES - 1)) begin
					slot_r <= 8'h00;
					quanta_r <= quanta_r - 16'h0001;
				end else begin
					slot_r <= slot_r + 8'h01;
				end
			end
		end
	end
	assign TX_HOLD = (quanta_r != 16'h0000);

	// ----------------------------------------
	// Packet filter flag for received pause
	// ----------------------------------------
	// Flag only marks the frame; delivery itself is never gated here
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			filt_r <= 1'b0;
		end else if (CE && RX_PAUSE_VALID) begin
			filt_r <= pass_r;
		end
	end
	assign RX_FILTER_FLAG = filt_r;

endmodule : mmpc_dev

`default_nettype wire

// *** mmpc_host.sv ***
// Host end: sequences register accesses to the device for PHY reads, PHY writes and flow setup.
// Assumes the device answers reads one cycle after the strobe and never stalls.
`timescale 1ns/1ps
`default_nettype none

module mmpc_host (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE,
	// Register port to device
	mmpc_bus_if.host BUS,
	// User command port
	input wire logic [3:0] U_ADDR,
	input wire logic [31:0] U_WDATA,
	input wire logic U_WR,
	input wire logic U_RD,
	output logic [31:0] U_RDATA
);

	typedef enum logic [6:0] {
		H_IDLE = 7'h01,
		H_WAIT = 7'h02,
		H_EVAL = 7'h04,
		H_WACC = 7'h08,
		H_POLL = 7'h10,
		H_FETCH = 7'h20,
		H_GRAB = 7'h40
	} mmpc_hstate_t;

	mmpc_hstate_t state_r;
	logic [9:0] cmd_r;
	logic [31:0] arg_r;
	logic [15:0] result_r;
	logic after_r;
	logic [mmpc_pkg::ADDR_W-1:0] addr_r;
	logic [31:0] wdata_r;
	logic wr_r;
	logic rd_r;
	logic [31:0] urd_r;
	logic go;

	assign go = U_WR && (U_ADDR == mmpc_pkg::HOST_CMD) && (state_r == H_IDLE);

	// ----------------------------------------
	// Command and argument registers
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cmd_r <= 10'h000;
			arg_r <= 32'h00000000;
		end else if (CE) begin
			if (go) begin
				cmd_r <= U_WDATA[9:0];
			end
			if (U_WR && U_ADDR == mmpc_pkg::HOST_ARG && state_r == H_IDLE) begin
				arg_r <= U_WDATA;
			end
		end
	end

	// ----------------------------------------
	// Sequencer and bus master
	// ----------------------------------------
	// Every write is preceded by a busy poll, so the device never sees one mid-access
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_r <= H_IDLE;
			after_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= 32'h00000000;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			result_r <= 16'h0000;
		end else if (CE) begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			unique case (state_r)
				H_IDLE: begin
					if (go) begin
						addr_r <= U_WDATA[mmpc_pkg::CMD_FLOW] ? mmpc_pkg::ADR_FLOW : mmpc_pkg::ADR_ACC;
						rd_r <= 1'b1;
						after_r <= 1'b0;
						state_r <= H_WAIT;
					end
				end
				H_WAIT: state_r <= H_EVAL;
				H_EVAL: begin
					if (BUS.rdata[0]) begin
						rd_r <= 1'b1;
						state_r <= H_WAIT;
					end else if (after_r && !cmd_r[mmpc_pkg::CMD_WR]) begin
						addr_r <= mmpc_pkg::ADR_DATA;
						rd_r <= 1'b1;
						state_r <= H_FETCH;
					end else if (after_r) begin
						state_r <= H_IDLE;
					end else if (cmd_r[mmpc_pkg::CMD_FLOW]) begin
						wdata_r <= {arg_r[31:16], 13'h0000, arg_r[2:1], 1'b0};
						wr_r <= 1'b1;
						state_r <= H_IDLE;
					end else begin
						addr_r <= mmpc_pkg::ADR_DATA;
						wdata_r <= {16'h0000, arg_r[15:0]};
						wr_r <= cmd_r[mmpc_pkg::CMD_WR];
						state_r <= H_WACC;
					end
				end
				H_WACC: begin
					addr_r <= mmpc_pkg::ADR_ACC;
					wdata_r <= {16'h0000, mmpc_pkg::PHY_ADDR_REQ, cmd_r[4:0], 4'h0,
						cmd_r[mmpc_pkg::CMD_WR], 1'b1};
					wr_r <= 1'b1;
					state_r <= H_POLL;
				end
				H_POLL: begin
					rd_r <= 1'b1;
					after_r <= 1'b1;
					state_r <= H_WAIT;
				end
				H_FETCH: state_r <= H_GRAB;
				H_GRAB: begin
					result_r <= BUS.rdata[15:0];
					state_r <= H_IDLE;
				end
				default: state_r <= H_IDLE;
			endcase
		end
	end
	assign BUS.addr = addr_r;
	assign BUS.wdata = wdata_r;
	assign BUS.wr = wr_r;
	assign BUS.rd = rd_r;

	// ----------------------------------------
	// User read port
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			urd_r <= 32'h00000000;
		end else if (CE && U_RD) begin
			unique case (U_ADDR)
				mmpc_pkg::HOST_CMD: urd_r <= {22'h000000, cmd_r};
				mmpc_pkg::HOST_ARG: urd_r <= arg_r;
				mmpc_pkg::HOST_STAT: urd_r <= {result_r, 15'h0000, state_r != H_IDLE};
				default: urd_r <= 32'h00000000;
			endcase
		end
	end
	assign U_RDATA = urd_r;

endmodule : mmpc_host

`default_nettype wire

// *** mmpc_asserts.sv ***
// Checker for the register port, the management pins and the flow pins.
// Assumes it sits beside the bus interface in the bench, on one clock with an active-low async reset.
`timescale 1ns/1ps
`default_nettype none

module mmpc_asserts (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Register port
	input wire logic [mmpc_pkg::ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	// Management pins
	input wire logic MDC,
	input wire logic MDIO_O,
	input wire logic MDIO_OE,
	// Flow pins
	input wire logic FULL_DUPLEX,
	input wire logic TX_ENABLE,
	input wire logic FC_REQ,
	input wire logic PAUSE_SEND,
	input wire logic BACKPRESSURE,
	input wire logic RX_PAUSE_VALID,
	input wire logic TX_HOLD
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	// ----------------------------------------
	// Frame position
	// ----------------------------------------
	logic oe_r;
	logic [10:0] cnt_r;

	// Cycles since the driver came on; saturates so long idle spells never wrap into a frame
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			oe_r <= 1'b0;
			cnt_r <= 11'h7FF;
		end else begin
			oe_r <= MDIO_OE;
			if (MDIO_OE && !oe_r) begin
				cnt_r <= 11'h001;
			end else if (cnt_r != 11'h7FF) begin
				cnt_r <= cnt_r + 11'h001;
			end
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence acc_start_s;
		wr && addr == mmpc_pkg::ADR_ACC && wdata[mmpc_pkg::ACC_BUSY];
	endsequence
	sequence mdc_high_s;
		MDC [*4] ##1 !MDC;
	endsequence

	acc_write_a: assert property (wr && addr == mmpc_pkg::ADR_ACC |-> wdata[15:11] == 5'h01 && wdata[0])
		else $error("access write without fixed PHY address or busy");
	flow_write_a: assert property (wr && addr == mmpc_pkg::ADR_FLOW |-> !wdata[mmpc_pkg::FLOW_BUSY])
		else $error("flow write with busy bit set");
	access_start_a: assert property ($rose(MDIO_OE) |-> $past(wr && addr == mmpc_pkg::ADR_ACC && wdata[0]))
		else $error("frame started without an access request");
	start_seq_a: assert property (acc_start_s |=> MDIO_OE && MDIO_O)
		else $error("access request did not start a frame");
	mdc_high_a: assert property ($rose(MDC) |=> mdc_high_s)
		else $error("management clock high phase not five cycles");
	preamble_ones_a: assert property (MDIO_OE && cnt_r < 11'h140 |-> MDIO_O)
		else $error("preamble bit not one");
	start_bits_a: assert property (cnt_r >= 11'h140 && cnt_r < 11'h14A |-> MDIO_OE && !MDIO_O)
		else $error("start delimiter first bit not zero");
	oe_end_a: assert property ($rose(MDIO_OE) |-> ##[400:700] !MDIO_OE)
		else $error("frame driver never released");
	rdata_cause_a: assert property ($changed(rdata) |-> $past(rd))
		else $error("read data changed without a read");
	pause_cause_a: assert property ($rose(PAUSE_SEND) |-> $past(FC_REQ && TX_ENABLE && FULL_DUPLEX))
		else $error("pause frame wanted without a request");
	bp_off_a: assert property (!TX_ENABLE |=> !BACKPRESSURE)
		else $error("backpressure with transmitter disabled");
	hold_cause_a: assert property ($rose(TX_HOLD) |-> $past(RX_PAUSE_VALID))
		else $error("transmit hold without received pause");
endmodule : mmpc_asserts

`default_nettype wire

// *** test_mii_mgmt_and_pause_ctrl.sv ***
// Bench joining host end and device end, with an emulated PHY on the data pin.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHECK_EQ(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR %s expected %h seen %h", what, exp, got); end end

module test_mii_mgmt_and_pause_ctrl;
	localparam logic [15:0] PHY_PAT = 16'hA5C3;
	localparam int SLOT = 2;
	logic clk, rst_b, u_wr, u_rd, fd, tx_en, fc_req, p_sent, rx_v;
	logic [3:0] u_addr;
	logic [31:0] u_wdata, u_rdata;
	logic [15:0] rx_q, p_time;
	logic mdc, mdio_o, mdio_oe, p_send, bp, tx_hold, filt, oe_r;
	logic [10:0] fc_r = 11'h7FF;
	logic [63:0] cap_r = 64'h0;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	wire logic mdio;
	wire logic phy_oe;
	wire logic phy_v;

	// ----------------------------------------
	// Emulated PHY: turnaround zero, then data MSB first
	// ----------------------------------------
	assign phy_oe = !mdio_oe && fc_r >= 11'h1D6 && fc_r < 11'h280;
	assign phy_v = (fc_r < 11'h1E0) ? 1'b0 : PHY_PAT[4'hF - 4'((fc_r - 11'h1E0) / 11'h00A)];
	assign mdio = mdio_oe ? mdio_o : (phy_oe ? phy_v : 1'b1); // Pull-up when released

	// Frame position and capture of every bit seen at the clock rise
	always @(posedge clk) begin
		oe_r <= mdio_oe;
		if (mdio_oe && !oe_r) fc_r <= 11'h001;
		else if (fc_r != 11'h7FF) fc_r <= fc_r + 11'h001;
	end
	always @(posedge mdc) cap_r <= {cap_r[62:0], mdio};

	mmpc_bus_if u_mmpc_bus_if ();
	mmpc_host u_mmpc_host (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .BUS(u_mmpc_bus_if.host), .U_ADDR(u_addr),
		.U_WDATA(u_wdata), .U_WR(u_wr), .U_RD(u_rd), .U_RDATA(u_rdata));
	mmpc_dev #(.SLOT_CYCLES(SLOT)) u_mmpc_dev (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .BUS(u_mmpc_bus_if.dev),
		.MDC(mdc), .MDIO_I(mdio), .MDIO_O(mdio_o), .MDIO_OE(mdio_oe), .FULL_DUPLEX(fd), .TX_ENABLE(tx_en),
		.FC_REQ(fc_req), .PAUSE_SENT(p_sent), .PAUSE_SEND(p_send), .PAUSE_TIME(p_time), .BACKPRESSURE(bp),
		.TX_HOLD(tx_hold), .RX_PAUSE_VALID(rx_v), .RX_PAUSE_QUANTA(rx_q), .RX_FILTER_FLAG(filt));
	mmpc_asserts u_mmpc_asserts (.CLK(clk), .RST_B(rst_b), .addr(u_mmpc_bus_if.addr),
		.wdata(u_mmpc_bus_if.wdata), .wr(u_mmpc_bus_if.wr), .rd(u_mmpc_bus_if.rd), .rdata(u_mmpc_bus_if.rdata),
		.MDC(mdc), .MDIO_O(mdio_o), .MDIO_OE(mdio_oe), .FULL_DUPLEX(fd), .TX_ENABLE(tx_en), .FC_REQ(fc_req),
		.PAUSE_SEND(p_send), .BACKPRESSURE(bp), .RX_PAUSE_VALID(rx_v), .TX_HOLD(tx_hold));

	// ----------------------------------------
	// User port cycles
	// ----------------------------------------
	task automatic uw(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		u_addr <= a;
		u_wdata <= d;
		u_wr <= 1'b1;
		@(posedge clk);
		u_wr <= 1'b0;
	endtask : uw

	// Data stand in the cycle after the strobe, taken at the edge that ends it
	task automatic ur(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		u_addr <= a;
		u_rd <= 1'b1;
		@(posedge clk);
		u_rd <= 1'b0;
		@(posedge clk);
		d = u_rdata;
	endtask : ur

	// Bounded poll, so a stuck busy ends as a mismatch rather than a hang
	task automatic wait_idle(output logic [31:0] s);
		s = 32'h1;
		for (int i = 0; i < 400 && s[0] !== 1'b0; i++) ur(mmpc_pkg::HOST_STAT, s);
		`CHECK_EQ("busy cleared", 1'b0, s[0])
	endtask : wait_idle

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Status and pause time straight after reset
	task automatic s_reset;
		logic [31:0] s;
		ur(mmpc_pkg::HOST_STAT, s);
		`CHECK_EQ("status at reset", 32'h00000000, s)
		`CHECK_EQ("pause time at reset", 16'h0000, p_time)
	endtask : s_reset

	task automatic s_phy(input logic wnr, input logic [4:0] idx, input logic [15:0] d);
		logic [31:0] s;
		logic [63:0] frm;
		uw(mmpc_pkg::HOST_ARG, {16'h0000, d});
		uw(mmpc_pkg::HOST_CMD, {23'h000000, wnr, 3'h0, idx});
		repeat (300) @(posedge clk);
		ur(mmpc_pkg::HOST_STAT, s);
		`CHECK_EQ("busy mid access", 1'b1, s[0])
		wait_idle(s);
		// Expected frame built first, so no braced commas pass through the macro
		frm = {mmpc_pkg::PREAMBLE, mmpc_pkg::SOF, (wnr ? mmpc_pkg::OP_WRITE : mmpc_pkg::OP_READ),
			5'h01, idx, mmpc_pkg::TA_WRITE, (wnr ? d : PHY_PAT)};
		`CHECK_EQ("frame bits", frm, cap_r)
		if (!wnr) `CHECK_EQ("read result", PHY_PAT, s[31:16])
	endtask : s_phy

	task automatic s_flow_cfg(input logic [15:0] pt, input logic pass, input logic en);
		logic [31:0] s;
		uw(mmpc_pkg::HOST_ARG, {pt, 13'h0000, pass, en, 1'b0});
		uw(mmpc_pkg::HOST_CMD, 32'h00000200);
		wait_idle(s);
		`CHECK_EQ("pause time", pt, p_time)
	endtask : s_flow_cfg

	// Full duplex pause request, then half duplex backpressure, each checked with transmitter on, then off
	task automatic s_pause_tx;
		s_flow_cfg(16'h1234, 1'b1, 1'b1);
		@(posedge clk);
		fc_req <= 1'b1;
		repeat (2) @(posedge clk);
		#1 `CHECK_EQ("pause wanted", 1'b1, p_send)
		@(posedge clk);
		p_sent <= 1'b1;
		fc_req <= 1'b0;
		@(posedge clk);
		p_sent <= 1'b0;
		@(posedge clk);
		#1 `CHECK_EQ("pause done", 1'b0, p_send)
		@(posedge clk);
		tx_en <= 1'b0;
		fc_req <= 1'b1;
		repeat (3) @(posedge clk);
		#1 `CHECK_EQ("pause tx off", 1'b0, p_send)
		@(posedge clk);
		fd <= 1'b0;
		tx_en <= 1'b1;
		repeat (2) @(posedge clk);
		#1 `CHECK_EQ("backpressure", 1'b1, bp)
		@(posedge clk);
		tx_en <= 1'b0;
		repeat (2) @(posedge clk);
		#1 `CHECK_EQ("backpressure tx off", 1'b0, bp)
		@(posedge clk);
		fc_req <= 1'b0;
		fd <= 1'b1;
		tx_en <= 1'b1;
	endtask : s_pause_tx

	task automatic s_pause_rx(input logic pass, input logic en);
		int n;
		n = 0;
		s_flow_cfg(16'h0001, pass, en);
		@(posedge clk);
		rx_v <= 1'b1;
		rx_q <= 16'h0003;
		@(posedge clk);
		rx_v <= 1'b0;
		repeat (12) begin
			#1 n += int'(tx_hold !== 1'b0); // Unknown counts as hold, so it cannot pass
			@(posedge clk);
		end
		`CHECK_EQ("hold cycles", (en ? 3 * SLOT : 0), n)
		`CHECK_EQ("filter flag", pass, filt)
		// With flow enable off, half duplex requests give no backpressure
		if (!en) begin
			@(posedge clk);
			fd <= 1'b0;
			fc_req <= 1'b1;
			repeat (2) @(posedge clk);
			#1 `CHECK_EQ("backpressure disabled", 1'b0, bp)
			@(posedge clk);
			fd <= 1'b1;
			fc_req <= 1'b0;
		end
	endtask : s_pause_rx

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Whole run is under two thousand cycles; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			$display("ERROR run time expected finish seen hang");
			end_of_test();
		end
	end

	initial begin
		{u_wr, u_rd, p_sent, rx_v, fc_req, rst_b} = 6'h00;
		{fd, tx_en} = 2'h3;
		u_addr = 4'h0;
		u_wdata = 32'h00000000;
		rx_q = 16'h0000;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		s_reset();
		s_phy(1'b1, 5'h1F, 16'h8001);
		s_phy(1'b0, 5'h0A, 16'h0000);
		s_pause_tx();
		s_pause_rx(1'b1, 1'b1);
		s_pause_rx(1'b0, 1'b0);
		end_of_test();
	end
endmodule : test_mii_mgmt_and_pause_ctrl

`default_nettype wire
